// *** pkg/epi_defines.svh ***
`ifndef EPI_DEFINES_SVH
`define EPI_DEFINES_SVH
// register indices, byte address is four times the index
`define IDX_FLAG     8'h1c
`define IDX_MASK     8'h1d
`define IDX_SENSE    8'h1e
`define IDX_GRP_EN   8'h1f
`define IDX_GRP_FLAG 8'h20
`define IDX_GMASK0   8'h21
`define IDX_GMASK1   8'h22
`define IDX_GMASK2   8'h23
// sense field codes
`define SENSE_LOW    2'h0
`define SENSE_ANY    2'h1
`define SENSE_FALL   2'h2
`define SENSE_RISE   2'h3
// bus answers
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
// request slots
`define REQ_PIN0     0
`define REQ_PIN1     1
`define REQ_GRP0     2
`define REQ_GRP1     3
`define REQ_GRP2     4
`endif

// *** pkg/epi_pkg.sv ***
`default_nettype none
package epi_pkg;
  typedef struct packed {
    logic [1:0]  ext_s1;
    logic [1:0]  ext_s2;
    logic [1:0]  ext_prev;
    logic [23:0] pc_s1;
    logic [23:0] pc_s2;
    logic [23:0] pc_prev;
    logic [1:0]  emask;
    logic [3:0]  sense;
    logic [2:0]  gen;
    logic [7:0]  gmask0;
    logic [6:0]  gmask1;
    logic [7:0]  gmask2;
    logic [1:0]  eflag;
    logic [2:0]  gflag;
    logic [4:0]  req;
    logic        wake;
    logic        awready;
    logic        wready;
    logic        arready;
    logic        aw_got;
    logic        w_got;
    logic        w_en;
    logic        bvalid;
    logic        rvalid;
    logic [7:0]  aw_idx;
    logic [7:0]  wdata;
    logic [7:0]  rd_idx;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } state_t;
endpackage
`default_nettype wire

// *** logic/external_pin_interrupt_unit.sv ***
// Summary of operation
// - pins raise requests even when driven outputs
// - groups 2,1,0 cover bits 23..16, 14..8, 7..0
// - per-group masks select contributing inputs
// - pin-change detection works without I/O clock
// - level mode requests while pin stays low
// - edge detection needs the I/O clock running
// - low level detected without clock, wakes part
// - I/O clock stopped in sleep except idle
// - short wake level wakes without raising request
// - sense fields: pin1 bits 3:2, pin0 1:0
// - codes: low, any change, falling, rising
// - pin sampled first; longer pulses always caught
// - forward only with pin enable and global enable
// - enable mask bits 7..2 read zero
// - each pin and group has its own vector
// - pending flag: set on edge, cleared, level zero
// - group requests need group and global enable
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "epi_defines.svh"
module external_pin_interrupt_unit
  import epi_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic [9:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [9:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  input  wire logic        i_ext_request_pin_zero,
  input  wire logic        i_ext_request_pin_one,
  input  wire logic [23:0] i_pin_change_inputs,
  input  wire logic        i_global_enable,
  input  wire logic        i_io_clk_en,
  input  wire logic [4:0]  i_vector_taken,
  output logic             o_request_pin_zero,
  output logic             o_request_pin_one,
  output logic             o_pin_group_zero_request,
  output logic             o_pin_group_one_request,
  output logic             o_pin_group_two_request,
  output logic             o_wake
);

  state_t st_reg;
  state_t st_next;

  // one decode shared by write answer and read answer
  function automatic logic is_mapped(input logic [7:0] idx);
    is_mapped = (idx >= `IDX_FLAG) && (idx <= `IDX_GMASK2);
  endfunction

  // sense code against current and previous sample
  function automatic logic edge_hit(input logic [1:0] mode, input logic cur, input logic old);
    unique case (mode)
      `SENSE_LOW:  edge_hit = 1'b0;
      `SENSE_ANY:  edge_hit = cur ^ old;
      `SENSE_FALL: edge_hit = old & ~cur;
      `SENSE_RISE: edge_hit = cur & ~old;
    endcase
  endfunction

  // any enabled input of a group toggled
  function automatic logic any_toggle(input logic [7:0] tog, input logic [7:0] msk);
    any_toggle = |(tog & msk);
  endfunction

  // register read mux, reserved bits come back zero
  function automatic logic [31:0] read_reg(input logic [7:0] idx, input state_t s);
    case (idx)
      `IDX_FLAG:     read_reg = 32'(s.eflag);
      `IDX_MASK:     read_reg = 32'(s.emask);
      `IDX_SENSE:    read_reg = 32'(s.sense);
      `IDX_GRP_EN:   read_reg = 32'(s.gen);
      `IDX_GRP_FLAG: read_reg = 32'(s.gflag);
      `IDX_GMASK0:   read_reg = 32'(s.gmask0);
      `IDX_GMASK1:   read_reg = 32'(s.gmask1);
      `IDX_GMASK2:   read_reg = 32'(s.gmask2);
      default:       read_reg = 32'h0;
    endcase
  endfunction

  // whole next state
  always_comb begin
    logic [1:0] mode;
    logic [1:0] eset;
    logic [1:0] eclr;
    logic [2:0] gset;
    logic [2:0] gclr;
    logic [23:0] tog;
    logic       low_wake;
    logic       wr;
    mode = 2'h0;
    eset = 2'h0;
    gset = 3'h0;
    tog = 24'h0;
    wr = 1'b0;
    eclr = i_vector_taken[`REQ_PIN1:`REQ_PIN0];
    gclr = i_vector_taken[`REQ_GRP2:`REQ_GRP0];
    low_wake = 1'b0;
    st_next = st_reg;

    // pins are read whatever their direction, so software can force events
    st_next.ext_s1 = {i_ext_request_pin_one, i_ext_request_pin_zero};
    st_next.ext_s2 = st_reg.ext_s1;
    st_next.ext_prev = st_reg.ext_s2;
    st_next.pc_s1 = i_pin_change_inputs;
    st_next.pc_s2 = st_reg.pc_s1;
    st_next.pc_prev = st_reg.pc_s2;

    // pin change compare ignores the I/O clock enable
    tog = st_reg.pc_s2 ^ st_reg.pc_prev;
    gset[0] = any_toggle(tog[7:0], st_reg.gmask0);
    gset[1] = any_toggle({1'b0, tog[14:8]}, {1'b0, st_reg.gmask1});
    gset[2] = any_toggle(tog[23:16], st_reg.gmask2);

    // write channel capture, either order
    if (i_awvalid && st_reg.awready) begin
      st_next.aw_got = 1'b1;
      st_next.aw_idx = i_awaddr[9:2];
    end
    if (i_wvalid && st_reg.wready) begin
      st_next.w_got = 1'b1;
      st_next.wdata = i_wdata[7:0];
      st_next.w_en = i_wstrb[0];
    end
    if (st_reg.bvalid && i_bready) begin
      st_next.bvalid = 1'b0;
    end
    wr = st_next.aw_got && st_next.w_got && !st_reg.bvalid;
    if (wr) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = is_mapped(st_next.aw_idx) ? `RESP_OKAY : `RESP_SLVERR;
      if (st_next.w_en) begin
        case (st_next.aw_idx)
          `IDX_FLAG:     eclr = eclr | st_next.wdata[1:0];
          `IDX_MASK:     st_next.emask = st_next.wdata[1:0];
          `IDX_SENSE:    st_next.sense = st_next.wdata[3:0];
          `IDX_GRP_EN:   st_next.gen = st_next.wdata[2:0];
          `IDX_GRP_FLAG: gclr = gclr | st_next.wdata[2:0];
          `IDX_GMASK0:   st_next.gmask0 = st_next.wdata;
          `IDX_GMASK1:   st_next.gmask1 = st_next.wdata[6:0];
          `IDX_GMASK2:   st_next.gmask2 = st_next.wdata;
          default:       ;
        endcase
      end
    end

    // read channel, answer one cycle after the address
    if (st_reg.rvalid && i_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (i_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rd_idx = i_araddr[9:2];
      st_next.rdata = read_reg(i_araddr[9:2], st_reg);
      st_next.rresp = is_mapped(i_araddr[9:2]) ? `RESP_OKAY : `RESP_SLVERR;
    end
    st_next.awready = !st_next.aw_got && !st_next.bvalid;
    st_next.wready = !st_next.w_got && !st_next.bvalid;
    st_next.arready = !st_next.rvalid;

    // dedicated pins: edges only while the I/O clock runs
    for (int i = 0; i < 2; i++) begin
      mode = st_reg.sense[2*i +: 2];
      eset[i] = i_io_clk_en && edge_hit(mode, st_reg.ext_s2[i], st_reg.ext_prev[i]);
    end
    // set wins over a clear arriving in the same cycle
    st_next.eflag = (st_reg.eflag & ~eclr) | eset;
    st_next.gflag = (st_reg.gflag & ~gclr) | gset;

    // level mode: flag held clear, request follows the pin
    for (int i = 0; i < 2; i++) begin
      mode = st_reg.sense[2*i +: 2];
      if (mode == `SENSE_LOW) begin
        st_next.eflag[i] = 1'b0;
        st_next.req[i] = st_reg.emask[i] && i_global_enable && !st_reg.ext_s2[i];
        low_wake = low_wake || (st_reg.emask[i] && !st_reg.ext_s2[i]);
      end else begin
        st_next.req[i] = st_reg.emask[i] && i_global_enable && st_reg.eflag[i];
      end
    end
    // one request line per vector
    for (int g = 0; g < 3; g++) begin
      st_next.req[`REQ_GRP0+g] = st_reg.gen[g] && i_global_enable && st_reg.gflag[g];
    end
    // wake does not need the global enable; request may still not follow
    st_next.wake = low_wake || |(st_reg.gflag & st_reg.gen);
  end

  // all state zero at reset, nothing enabled
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign o_awready = st_reg.awready;
  assign o_wready = st_reg.wready;
  assign o_bresp = st_reg.bresp;
  assign o_bvalid = st_reg.bvalid;
  assign o_arready = st_reg.arready;
  assign o_rdata = st_reg.rdata;
  assign o_rresp = st_reg.rresp;
  assign o_rvalid = st_reg.rvalid;
  assign o_request_pin_zero = st_reg.req[`REQ_PIN0];
  assign o_request_pin_one = st_reg.req[`REQ_PIN1];
  assign o_pin_group_zero_request = st_reg.req[`REQ_GRP0];
  assign o_pin_group_one_request = st_reg.req[`REQ_GRP1];
  assign o_pin_group_two_request = st_reg.req[`REQ_GRP2];
  assign o_wake = st_reg.wake;

  // level low with enables gives a request next cycle
  property p_level_req;
    @(posedge i_ref_clk) disable iff (i_rst)
    (st_reg.sense[1:0] == `SENSE_LOW && st_reg.emask[0] && !st_reg.ext_s2[0] && i_global_enable)
      |=> o_request_pin_zero;
  endproperty
  a_level_req: assert property (p_level_req) else $error("level request missing");

  property p_level_flag;
    @(posedge i_ref_clk) disable iff (i_rst)
    (st_reg.sense[3:2] == `SENSE_LOW) |=> !st_reg.eflag[1];
  endproperty
  a_level_flag: assert property (p_level_flag) else $error("flag set in level mode");

  property p_fall_sets;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_io_clk_en && st_reg.sense[1:0] == `SENSE_FALL && st_reg.ext_prev[0] && !st_reg.ext_s2[0])
      |=> st_reg.eflag[0];
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("falling edge lost");

  property p_no_edge_sleep;
    @(posedge i_ref_clk) disable iff (i_rst)
    (!i_io_clk_en && !st_reg.eflag[0]) |=> !st_reg.eflag[0];
  endproperty
  a_no_edge_sleep: assert property (p_no_edge_sleep) else $error("edge seen without clock");

  property p_group_toggle;
    @(posedge i_ref_clk) disable iff (i_rst)
    (|((st_reg.pc_s2[23:16] ^ st_reg.pc_prev[23:16]) & st_reg.gmask2)) |=> st_reg.gflag[2];
  endproperty
  a_group_toggle: assert property (p_group_toggle) else $error("group toggle lost");

  property p_masked_off;
    @(posedge i_ref_clk) disable iff (i_rst)
    (st_reg.gmask0 == 8'h00 && !st_reg.gflag[0]) |=> !st_reg.gflag[0];
  endproperty
  a_masked_off: assert property (p_masked_off) else $error("masked input set flag");

  property p_enable_gate;
    @(posedge i_ref_clk) disable iff (i_rst)
    o_request_pin_one |-> $past(st_reg.emask[1]) && $past(i_global_enable);
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("request without enables");

  property p_group_gate;
    @(posedge i_ref_clk) disable iff (i_rst)
    o_pin_group_one_request |-> $past(st_reg.gen[1]) && $past(st_reg.gflag[1]);
  endproperty
  a_group_gate: assert property (p_group_gate) else $error("group request without enable");

  property p_mask_reserved;
    @(posedge i_ref_clk) disable iff (i_rst)
    (o_rvalid && st_reg.rd_idx == `IDX_MASK) |-> o_rdata[31:2] == 30'h0;
  endproperty
  a_mask_reserved: assert property (p_mask_reserved) else $error("reserved mask bits set");

  property p_low_wake;
    @(posedge i_ref_clk) disable iff (i_rst)
    (st_reg.sense[1:0] == `SENSE_LOW && st_reg.emask[0] && !st_reg.ext_s2[0]) |=> o_wake;
  endproperty
  a_low_wake: assert property (p_low_wake) else $error("low level gave no wake");

  // vector taken with no fresh edge behind it leaves the flag clear
  property p_pin_taken;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_vector_taken[`REQ_PIN0] && (st_reg.ext_s2[0] == st_reg.ext_prev[0])) |=> !st_reg.eflag[0];
  endproperty
  a_pin_taken: assert property (p_pin_taken) else $error("pending flag not cleared");

  property p_sense_reserved;
    @(posedge i_ref_clk) disable iff (i_rst)
    (o_rvalid && st_reg.rd_idx == `IDX_SENSE) |-> o_rdata[31:4] == 28'h0;
  endproperty
  a_sense_reserved: assert property (p_sense_reserved) else $error("reserved sense bits set");

  // input 15 sits outside every group, its toggle must not count
  property p_input15_ignored;
    @(posedge i_ref_clk) disable iff (i_rst)
    ((st_reg.pc_s2[15] ^ st_reg.pc_prev[15]) && !st_reg.gflag[1]
      && !(|((st_reg.pc_s2[14:8] ^ st_reg.pc_prev[14:8]) & st_reg.gmask1))) |=> !st_reg.gflag[1];
  endproperty
  a_input15_ignored: assert property (p_input15_ignored) else $error("input 15 set group flag");

endmodule
`default_nettype wire

// *** bench/pin_source_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module pin_source_model (
  input  wire logic        i_ref_clk,
  output logic             o_pin_zero,
  output logic             o_pin_one,
  output logic [23:0]      o_pin_change
);
  // dedicated pin lines rest high, as if pulled up; pin-change lines start low
  initial begin
    o_pin_zero = 1'b1;
    o_pin_one = 1'b1;
    o_pin_change = 24'h000000;
  end
  // levels move just after an edge and stand until the next call
  task automatic drive(input logic z, input logic o, input logic [23:0] p);
    @(posedge i_ref_clk);
    o_pin_zero <= z;
    o_pin_one <= o;
    o_pin_change <= p;
  endtask
endmodule
`default_nettype wire

// *** bench/external_pin_interrupt_unit_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "epi_defines.svh"
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fails++; $display("Error %s exp %0h got %0h", n, e, a); end end
module external_pin_interrupt_unit_tb;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [9:0]  awaddr = 10'h000;
  logic [9:0]  araddr = 10'h000;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, pin0, pin1, wake;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [23:0] pc;
  logic        ge = 1'b0, io_en = 1'b1;
  logic [4:0]  vt = 5'h00;
  logic [3:0]  wstrb = 4'hf;
  logic [4:0]  req;
  int          fails = 0, checked = 0;
  logic [23:0] p;
  always #50 ref_clk = ~ref_clk;
  pin_source_model pin_source_model_inst (.i_ref_clk(ref_clk), .o_pin_zero(pin0), .o_pin_one(pin1), .o_pin_change(pc));
  external_pin_interrupt_unit external_pin_interrupt_unit_inst (
    .i_ref_clk(ref_clk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_ext_request_pin_zero(pin0), .i_ext_request_pin_one(pin1), .i_pin_change_inputs(pc),
    .i_global_enable(ge), .i_io_clk_en(io_en), .i_vector_taken(vt),
    .o_request_pin_zero(req[0]), .o_request_pin_one(req[1]), .o_pin_group_zero_request(req[2]),
    .o_pin_group_one_request(req[3]), .o_pin_group_two_request(req[4]), .o_wake(wake));
  task automatic conclude();
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // both write channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic a;
    logic w;
    a = 1'b1;
    w = 1'b1;
    @(posedge ref_clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (a || w) begin
      @(posedge ref_clk);
      if (awready) a = 1'b0;
      if (wready) w = 1'b0;
      if (!a) awvalid <= 1'b0;
      if (!w) wvalid <= 1'b0;
    end
    while (!bvalid) @(posedge ref_clk);
    bready <= 1'b0;
    `CHK("bresp", (idx >= `IDX_FLAG && idx <= `IDX_GMASK2) ? `RESP_OKAY : `RESP_SLVERR, bresp)
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] e, input logic [1:0] er);
    @(posedge ref_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge ref_clk);
    while (!arready) @(posedge ref_clk);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge ref_clk);
    rready <= 1'b0;
    `CHK("rdata", e, rdata)
    `CHK("rresp", er, rresp)
  endtask
  // one-cycle vector acknowledge
  task automatic take(input logic [4:0] v);
    @(posedge ref_clk);
    vt <= v;
    @(posedge ref_clk);
    vt <= 5'h00;
  endtask
  // hang guard, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    for (int i = 8'h1c; i <= 8'h23; i++) rdc(8'(i), 32'h0, `RESP_OKAY);
    rdc(8'h00, 32'h0, `RESP_SLVERR);
    // low byte lane off: answer okay, register untouched
    wstrb <= 4'h0;
    wr(`IDX_GMASK0, 8'hff);
    rdc(`IDX_GMASK0, 32'h0, `RESP_OKAY);
    wstrb <= 4'hf;
    wr(8'h00, 8'hff);
    rdc(8'h00, 32'h0, `RESP_SLVERR);
    wr(`IDX_MASK, 8'hff);
    rdc(`IDX_MASK, 32'h3, `RESP_OKAY);
    wr(`IDX_SENSE, 8'hff);
    rdc(`IDX_SENSE, 32'hf, `RESP_OKAY);
    ge <= 1'b1;
    // every sense code on both pins: falling then rising
    for (int c = 0; c < 4; c++) begin
      wr(`IDX_SENSE, 8'(c * 5));
      wr(`IDX_FLAG, 8'h03);
      pin_source_model_inst.drive(1'b0, 1'b0, pc);
      wt(6);
      `CHK("req fall", {2{c != 3}}, req[1:0])
      rdc(`IDX_FLAG, {30'h0, {2{c == 1 || c == 2}}}, `RESP_OKAY);
      wr(`IDX_FLAG, 8'h03);
      wt(3);
      `CHK("req held", {2{c == 0}}, req[1:0])
      pin_source_model_inst.drive(1'b1, 1'b1, pc);
      wt(6);
      `CHK("req rise", {2{c == 1 || c == 3}}, req[1:0])
      rdc(`IDX_FLAG, {30'h0, {2{c == 1 || c == 3}}}, `RESP_OKAY);
      wr(`IDX_FLAG, 8'h03);
      wt(3);
      `CHK("req clr", 2'b00, req[1:0])
    end
    // global and per-pin enables gate the requests, not the flags
    wr(`IDX_SENSE, 8'h0a);
    wr(`IDX_MASK, 8'h01);
    ge <= 1'b0;
    pin_source_model_inst.drive(1'b0, 1'b0, pc);
    wt(6);
    `CHK("req ge off", 2'b00, req[1:0])
    rdc(`IDX_FLAG, 32'h3, `RESP_OKAY);
    ge <= 1'b1;
    wt(3);
    `CHK("req ge on", 2'b01, req[1:0])
    take(5'h01);
    wt(3);
    rdc(`IDX_FLAG, 32'h2, `RESP_OKAY);
    `CHK("req taken", 2'b00, req[1:0])
    // pin one still pending, served through its own vector
    wr(`IDX_MASK, 8'h03);
    wt(3);
    `CHK("req pin1", 2'b10, req[1:0])
    take(5'h02);
    wt(3);
    `CHK("req pin1 taken", 2'b00, req[1:0])
    // edges while the io clock is stopped are lost
    pin_source_model_inst.drive(1'b1, 1'b1, pc);
    wr(`IDX_FLAG, 8'h03);
    io_en <= 1'b0;
    pin_source_model_inst.drive(1'b0, 1'b1, pc);
    wt(6);
    io_en <= 1'b1;
    wt(6);
    `CHK("req no clk", 2'b00, req[1:0])
    // pin-change groups, run with the io clock stopped
    io_en <= 1'b0;
    wr(`IDX_GRP_EN, 8'h07);
    wr(`IDX_GMASK0, 8'h01);
    wr(`IDX_GMASK1, 8'h40);
    wr(`IDX_GMASK2, 8'h80);
    p = pc;
    for (int k = 0; k < 5; k++) begin
      int b;
      logic [2:0] e;
      b = (k == 0) ? 1 : (k == 1) ? 0 : (k == 2) ? 15 : (k == 3) ? 14 : 23;
      e = (k == 1) ? 3'b001 : (k == 3) ? 3'b010 : (k == 4) ? 3'b100 : 3'b000;
      p[b] = ~p[b];
      pin_source_model_inst.drive(1'b0, 1'b1, p);
      wt(6);
      `CHK("group req", e, req[4:2])
      `CHK("wake", |e, wake)
      take({e, 2'b00});
      wt(3);
      `CHK("group clr", 3'b000, req[4:2])
    end
    conclude();
  end
endmodule
`default_nettype wire
